// ---- hdl/tpt_pkg.sv ----
/*
  Constants, register map and helper functions for the three-channel programmable timer.
  Assumes a 32-bit AXI4-Lite register bus in which each register holds one aligned word.
*/
package tpt_pkg;

  localparam int TPT_CNT_W = 16;
  localparam int TPT_ADDR_W = 12;

  // register indices; the byte address is four times the index
  localparam logic [9:0] TPT_T0_CNT_IDX = 10'h050;
  localparam logic [9:0] TPT_T0_LIMA_IDX = 10'h052;
  localparam logic [9:0] TPT_T0_LIMB_IDX = 10'h054;
  localparam logic [9:0] TPT_T0_CTRL_IDX = 10'h056;
  localparam logic [9:0] TPT_T1_CNT_IDX = 10'h058;
  localparam logic [9:0] TPT_T1_LIMA_IDX = 10'h05a;
  localparam logic [9:0] TPT_T1_LIMB_IDX = 10'h05c;
  localparam logic [9:0] TPT_T1_CTRL_IDX = 10'h05e;
  localparam logic [9:0] TPT_T2_CNT_IDX = 10'h060;
  localparam logic [9:0] TPT_T2_LIMA_IDX = 10'h062;
  localparam logic [9:0] TPT_T2_CTRL_IDX = 10'h066;

  // register kind codes returned by the decoder
  localparam logic [1:0] TPT_K_CNT = 2'h0;
  localparam logic [1:0] TPT_K_LIMA = 2'h1;
  localparam logic [1:0] TPT_K_LIMB = 2'h2;
  localparam logic [1:0] TPT_K_CTRL = 2'h3;

  // mode/control bit positions
  localparam int TPT_B_CONTINUOUS_RUN = 0;
  localparam int TPT_B_ALT = 1;
  localparam int TPT_B_EXT = 2;
  localparam int TPT_B_PRE = 3;
  localparam int TPT_B_RTG = 4;
  localparam int TPT_B_MC = 5;
  localparam int TPT_B_RIU = 12;
  localparam int TPT_B_INT = 13;
  localparam int TPT_B_INH = 14;
  localparam int TPT_B_EN = 15;

  // each timer gets one slot out of this many clocks
  localparam int TPT_SLOTS = 4;
  localparam logic [1:0] TPT_OUT_RST = 2'h3;

  localparam logic [1:0] TPT_RESP_OKAY = 2'h0;
  localparam logic [1:0] TPT_RESP_SLVERR = 2'h2;

  // {valid, timer[1:0], kind[1:0]}
  function automatic logic [4:0] tpt_decode(input logic [9:0] idx);
    logic [4:0] r;
    r = 5'h00;
    if (idx == TPT_T0_CNT_IDX) r = {3'b100, TPT_K_CNT};
    else if (idx == TPT_T0_LIMA_IDX) r = {3'b100, TPT_K_LIMA};
    else if (idx == TPT_T0_LIMB_IDX) r = {3'b100, TPT_K_LIMB};
    else if (idx == TPT_T0_CTRL_IDX) r = {3'b100, TPT_K_CTRL};
    else if (idx == TPT_T1_CNT_IDX) r = {3'b101, TPT_K_CNT};
    else if (idx == TPT_T1_LIMA_IDX) r = {3'b101, TPT_K_LIMA};
    else if (idx == TPT_T1_LIMB_IDX) r = {3'b101, TPT_K_LIMB};
    else if (idx == TPT_T1_CTRL_IDX) r = {3'b101, TPT_K_CTRL};
    else if (idx == TPT_T2_CNT_IDX) r = {3'b110, TPT_K_CNT};
    else if (idx == TPT_T2_LIMA_IDX) r = {3'b110, TPT_K_LIMA};
    else if (idx == TPT_T2_CTRL_IDX) r = {3'b110, TPT_K_CTRL};
    return r;
  endfunction

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] tpt_merge(input logic [15:0] old, input logic [15:0] wd, input logic [1:0] strb);
    return {strb[1] ? wd[15:8] : old[15:8], strb[0] ? wd[7:0] : old[7:0]};
  endfunction

  // {hit, next count}: the limit value itself is never kept
  function automatic logic [16:0] tpt_step(input logic [15:0] c, input logic [15:0] lim);
    logic [15:0] inc;
    inc = c + 16'h0001;
    if (inc == lim) return {1'b1, 16'h0000};
    return {1'b0, inc};
  endfunction

endpackage

// ---- hdl/tpt_pin_sync.sv ----
/*
  Two-stage synchronizer with rising-edge detection for the timer input pins.
  Assumes the pins are asynchronous to clk_sys; rise is a one-cycle pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module tpt_pin_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] pin_async,
  output logic [WIDTH-1:0] pin_level,
  output logic [WIDTH-1:0] pin_rise
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
    logic [WIDTH-1:0] prev;
  } tpt_sync_t;

  tpt_sync_t s_reg;
  tpt_sync_t s_next;

  always_comb begin
    s_next = s_reg;
    s_next.meta = pin_async;
    s_next.sync = s_reg.meta;
    s_next.prev = s_reg.sync;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // only the second stage and later are looked at
  assign pin_level = s_reg.sync;
  assign pin_rise = s_reg.sync & ~s_reg.prev;
endmodule
`default_nettype wire

// ---- hdl/tpt_timer.sv ----
/*
  Three 16-bit programmable timers behind an AXI4-Lite slave.
  Assumes one clock clk_sys and asynchronous active-low rst_n; timer input pins may be asynchronous.
*/
// The implementer's own choices: the register offsets and the AXI4-Lite interface to the registers.
// Overview of operation
// [R01] - alternate select 0 always compares limit A; 1 swaps A and B per terminal count
// [R02] - single-limit mode: output low one clock, the clock after terminal count
// [R03] - dual-limit mode: output low while limit B active, high while A active
// [R04] - continuous run keeps counting after terminal count; otherwise the timer halts, in dual-limit mode only after limit B
// [R05] - one-shot dual mode counts to A, then to B, then halts
// [R06] - external clocking counts synchronized rising edges of the input pin
// [R07] - external edges four clocks apart are all counted, latency at most six clocks
// [R08] - internal clocking counts every fourth clock, or on third timer terminal count
// [R09] - gate mode: count while synchronized pin high, hold while low
// [R10] - retrigger mode: first rising edge starts from zero, later edges clear again
// [R11] - run enable clear stops counting and ignores pin transitions
// [R12] - without continuous run the run enable clears itself at terminal count, in dual-limit mode only at that of limit B
// [R13] - run enable updates only when the write mask bit is one; mask reads zero
// [R14] - interrupt enable raises a request on every terminal count, A and B alike
// [R15] - clearing the interrupt enable never withdraws a request already raised
// [R16] - limit reached flag sets on every terminal count; only software clears it
// [R17] - limit in use bit read-only, zero means A, clear whenever alternate is off
// [R18] - third timer hardwires alternate, external, prescale, retrigger, in-use to zero
// [R19] - count registers read and write any time; a write takes effect at once
// [R20] - reset only on equality; a count above the limit wraps through all-ones
// [R21] - reset clears run enables and in-use state, outputs high
// [R22] - count returns to zero in the clock it reaches the limit
`timescale 1ns/1ps
`default_nettype none
module tpt_timer
  import tpt_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [tpt_pkg::TPT_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [tpt_pkg::TPT_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] timer_in,
  output logic [1:0] timer_out,
  output logic [2:0] timer_irq_req
);
  import tpt_pkg::*;

  typedef struct packed {
    logic [1:0] phase;
    logic [2:0][15:0] cnt;
    logic [2:0][15:0] limit_a;
    logic [1:0][15:0] limit_b;
    logic [2:0] en;
    logic [2:0] continuous_run;
    logic [2:0] irq_en;
    logic [2:0] limit_reached_flag;
    logic [2:0] alternate_compare_select;
    logic [2:0] external_clock_select;
    logic [2:0] prescale_select;
    logic [2:0] retrigger_select;
    logic [2:0] limit_in_use;
    logic [2:0] started;
    logic [2:0] pend_pin;
    logic [2:0] pend_pre;
    logic t2_tick;
    logic [1:0] out;
    logic [2:0] irq;
    logic aw_held;
    logic [TPT_ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } tpt_state_t;

  localparam tpt_state_t TPT_ST_RST = '{out: TPT_OUT_RST, default: '0};

  tpt_state_t s_reg;
  tpt_state_t s_next;
  logic [1:0] pin_level;
  logic [1:0] pin_rise;
  logic [2:0] hit;
  logic [2:0] cnt_wr;
  logic [2:0] ctrl_wr;
  logic do_wr;
  logic [4:0] dec_w;
  logic [4:0] dec_r;
  logic [2:0][15:0] ctrl_rb;

  tpt_pin_sync #(.WIDTH(2)) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pin_async(timer_in),
    .pin_level(pin_level),
    .pin_rise(pin_rise)
  );

  always_comb begin
    logic [2:0] lvl;
    logic [2:0] rise;
    logic slot;
    logic inc;
    logic clr;
    logic pev;
    logic pre_ok;
    logic [15:0] lim;
    logic [16:0] stp;
    logic [15:0] wd;
    logic [1:0] t;
    lvl = {1'b1, pin_level};
    rise = {1'b0, pin_rise};
    slot = 1'b0;
    inc = 1'b0;
    clr = 1'b0;
    pev = 1'b0;
    pre_ok = 1'b0;
    lim = 16'h0000;
    stp = 17'h00000;
    wd = 16'h0000;
    t = 2'h0;
    s_next = s_reg;
    hit = 3'h0;
    cnt_wr = 3'h0;
    ctrl_wr = 3'h0;
    for (int i = 0; i < 3; i++) begin
      ctrl_rb[i] = 16'h0000;
      ctrl_rb[i][TPT_B_EN] = s_reg.en[i];
      ctrl_rb[i][TPT_B_INT] = s_reg.irq_en[i];
      ctrl_rb[i][TPT_B_RIU] = s_reg.limit_in_use[i];
      ctrl_rb[i][TPT_B_MC] = s_reg.limit_reached_flag[i];
      ctrl_rb[i][TPT_B_RTG] = s_reg.retrigger_select[i];
      ctrl_rb[i][TPT_B_PRE] = s_reg.prescale_select[i];
      ctrl_rb[i][TPT_B_EXT] = s_reg.external_clock_select[i];
      ctrl_rb[i][TPT_B_ALT] = s_reg.alternate_compare_select[i];
      ctrl_rb[i][TPT_B_CONTINUOUS_RUN] = s_reg.continuous_run[i];
    end
    dec_w = tpt_decode(s_reg.aw_addr[11:2]);
    dec_r = tpt_decode(s_axi_araddr[11:2]);
    do_wr = s_reg.aw_held & s_reg.w_held & ~s_reg.bvalid;
    s_next.phase = s_reg.phase + 2'h1;

    for (int i = 0; i < 3; i++) begin
      slot = (s_reg.phase == 2'(i)); // [R08]
      inc = 1'b0;
      clr = 1'b0;
      // an edge arriving in the slot itself is used at once; that keeps latency within six clocks
      pev = s_reg.pend_pin[i] | (rise[i] & s_reg.en[i]); // [R07]
      pre_ok = ~s_reg.prescale_select[i] | s_reg.pend_pre[i] | s_reg.t2_tick; // [R08]
      if (s_reg.en[i]) begin
        if (s_reg.external_clock_select[i]) begin
          inc = slot & pev; // [R06]
        end else if (s_reg.retrigger_select[i]) begin
          if (slot & pev) begin
            clr = 1'b1; // [R10]
            s_next.started[i] = 1'b1;
          end else begin
            inc = slot & s_reg.started[i] & pre_ok;
          end
        end else begin
          inc = slot & lvl[i] & pre_ok; // [R09]
        end
      end else begin
        s_next.started[i] = 1'b0; // [R11]
      end
      s_next.pend_pin[i] = pev & ~slot & s_reg.en[i]; // [R11]
      s_next.pend_pre[i] = (s_reg.pend_pre[i] | s_reg.t2_tick) & ~slot;
      lim = (i < 2 && s_reg.limit_in_use[i]) ? s_reg.limit_b[i % 2] : s_reg.limit_a[i]; // [R01]
      stp = tpt_step(s_reg.cnt[i], lim); // [R20]
      if (clr) begin
        s_next.cnt[i] = 16'h0000;
      end else if (inc) begin
        s_next.cnt[i] = stp[15:0]; // [R22]
        hit[i] = stp[16];
      end
      if (hit[i]) begin
        s_next.limit_reached_flag[i] = 1'b1; // [R16]
        if (s_reg.alternate_compare_select[i]) begin
          s_next.limit_in_use[i] = ~s_reg.limit_in_use[i]; // [R01]
        end
        // one-shot dual mode runs A then B before stopping
        if (!s_reg.continuous_run[i] && (!s_reg.alternate_compare_select[i] || s_reg.limit_in_use[i])) begin
          s_next.en[i] = 1'b0; // [R04] [R05] [R12]
        end
      end
      // a one-cycle pulse; the interrupt controller holds it, so later mask changes cannot retract it
      s_next.irq[i] = hit[i] & s_reg.irq_en[i]; // [R14] [R15]
    end
    s_next.t2_tick = hit[2];

    if (s_axi_awvalid && s_reg.awready) begin
      s_next.aw_held = 1'b1;
      s_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_reg.wready) begin
      s_next.w_held = 1'b1;
      s_next.w_data = s_axi_wdata;
      s_next.w_strb = s_axi_wstrb;
    end
    if (do_wr) begin
      s_next.aw_held = 1'b0;
      s_next.w_held = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = dec_w[4] ? TPT_RESP_OKAY : TPT_RESP_SLVERR;
      t = dec_w[3:2];
      if (dec_w[4]) begin
        if (dec_w[1:0] == TPT_K_CNT) begin
          s_next.cnt[t] = tpt_merge(s_reg.cnt[t], s_reg.w_data[15:0], s_reg.w_strb[1:0]); // [R19]
          cnt_wr[t] = 1'b1;
        end else if (dec_w[1:0] == TPT_K_LIMA) begin
          s_next.limit_a[t] = tpt_merge(s_reg.limit_a[t], s_reg.w_data[15:0], s_reg.w_strb[1:0]);
        end else if (dec_w[1:0] == TPT_K_LIMB) begin
          s_next.limit_b[t[0]] = tpt_merge(s_reg.limit_b[t[0]], s_reg.w_data[15:0], s_reg.w_strb[1:0]);
        end else begin
          wd = tpt_merge(ctrl_rb[t], s_reg.w_data[15:0], s_reg.w_strb[1:0]);
          ctrl_wr[t] = 1'b1;
          if (wd[TPT_B_INH]) begin
            s_next.en[t] = wd[TPT_B_EN]; // [R13]
          end
          s_next.irq_en[t] = wd[TPT_B_INT];
          // a write of zero clears the flag, but a terminal count in the same cycle wins
          s_next.limit_reached_flag[t] = hit[t] | (s_reg.limit_reached_flag[t] & wd[TPT_B_MC]); // [R16]
          s_next.retrigger_select[t] = wd[TPT_B_RTG];
          s_next.prescale_select[t] = wd[TPT_B_PRE];
          s_next.external_clock_select[t] = wd[TPT_B_EXT];
          s_next.alternate_compare_select[t] = wd[TPT_B_ALT];
          s_next.continuous_run[t] = wd[TPT_B_CONTINUOUS_RUN];
        end
      end
    end else if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end
    s_next.awready = ~s_next.aw_held & ~s_next.bvalid;
    s_next.wready = ~s_next.w_held & ~s_next.bvalid;

    s_next.alternate_compare_select[2] = 1'b0; // [R18]
    s_next.external_clock_select[2] = 1'b0; // [R18]
    s_next.prescale_select[2] = 1'b0; // [R18]
    s_next.retrigger_select[2] = 1'b0; // [R18]
    for (int i = 0; i < 3; i++) begin
      if (!s_next.alternate_compare_select[i]) begin
        s_next.limit_in_use[i] = 1'b0; // [R17]
      end
    end
    for (int i = 0; i < 2; i++) begin
      s_next.out[i] = s_next.alternate_compare_select[i] ? ~s_next.limit_in_use[i] : ~hit[i]; // [R02] [R03]
    end

    if (s_axi_arvalid && s_reg.arready) begin
      s_next.rvalid = 1'b1;
      s_next.rdata = 32'h00000000;
      s_next.rresp = dec_r[4] ? TPT_RESP_OKAY : TPT_RESP_SLVERR;
      t = dec_r[3:2];
      if (dec_r[4]) begin
        if (dec_r[1:0] == TPT_K_CNT) s_next.rdata[15:0] = s_reg.cnt[t]; // [R19]
        else if (dec_r[1:0] == TPT_K_LIMA) s_next.rdata[15:0] = s_reg.limit_a[t];
        else if (dec_r[1:0] == TPT_K_LIMB) s_next.rdata[15:0] = s_reg.limit_b[t[0]];
        else s_next.rdata[15:0] = ctrl_rb[t]; // [R13]
      end
    end else if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
    s_next.arready = ~s_next.rvalid;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= TPT_ST_RST; // [R21]
    end else begin
      s_reg <= s_next;
    end
  end

  assign s_axi_awready = s_reg.awready;
  assign s_axi_wready = s_reg.wready;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_arready = s_reg.arready;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;
  assign timer_out = s_reg.out;
  assign timer_irq_req = s_reg.irq;

  single_pulse_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R02]
    (hit[0] && !s_reg.alternate_compare_select[0] && !ctrl_wr[0]) |=> !timer_out[0] ##1 timer_out[0])
    else $error("single-limit output pulse wrong");
  dual_level_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R03]
    s_reg.alternate_compare_select[1] |-> (timer_out[1] == !s_reg.limit_in_use[1]))
    else $error("dual-limit output does not follow limit in use");
  riu_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R17]
    !s_reg.alternate_compare_select[0] |-> !s_reg.limit_in_use[0])
    else $error("limit in use set while alternate off");
  oneshot_halt_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R12]
    (hit[1] && !s_reg.continuous_run[1] && !s_reg.alternate_compare_select[1] && !ctrl_wr[1]) |=> !s_reg.en[1])
    else $error("one-shot timer kept running");
  zero_on_limit_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R22]
    (hit[0] && !cnt_wr[0]) |=> (s_reg.cnt[0] == 16'h0000))
    else $error("count not zero after limit");
  slot_only_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R08]
    (s_reg.phase != 2'h2 && !cnt_wr[2]) |=> $stable(s_reg.cnt[2]))
    else $error("third timer counted outside its slot");
  halted_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R11]
    (!s_reg.en[0] && !cnt_wr[0]) |=> $stable(s_reg.cnt[0]))
    else $error("disabled timer changed count");
  mask_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R13]
    (ctrl_wr[1] && !(s_reg.w_strb[1] && s_reg.w_data[TPT_B_INH]) && !hit[1]) |=> (s_reg.en[1] == $past(s_reg.en[1])))
    else $error("run enable changed without mask bit");
  flag_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R16]
    hit[2] |=> s_reg.limit_reached_flag[2])
    else $error("limit reached flag not set");
  irq_raise_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R14]
    (hit[0] && s_reg.irq_en[0]) |=> timer_irq_req[0] ##1 !timer_irq_req[0])
    else $error("interrupt request not a one-cycle pulse");
  bvalid_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid)
    else $error("write response dropped");

  dual_swap_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    hit[0] && s_reg.alternate_compare_select[0] && s_reg.limit_in_use[0]);
  ext_count_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    s_reg.external_clock_select[1] && hit[1]);
  retrig_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    s_reg.retrigger_select[0] && s_reg.started[0] && pin_rise[0] && s_reg.en[0]);
  bus_read_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
    s_axi_rvalid && s_axi_rready && s_axi_rresp == TPT_RESP_OKAY);
endmodule
`default_nettype wire

// ---- bench/tpt_pin_src.sv ----
/*
  Behavioural source for the two timer input pins: gate levels and event edges.
  Assumes the testbench calls its tasks; edges never come closer than four clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module tpt_pin_src (
  input wire logic clk_sys,
  output logic [1:0] pin
);
  initial pin = 2'b00;

  // levels are always driven, so no release state exists on these lines
  task automatic set_level(input int i, input logic v);
    @(posedge clk_sys);
    pin[i] <= v;
  endtask

  // one edge per gap clocks; gap below four would lose edges
  task automatic pulses(input int i, input int n, input int gap);
    repeat (n) begin
      @(posedge clk_sys);
      pin[i] <= 1'b1;
      repeat (gap / 2) @(posedge clk_sys);
      pin[i] <= 1'b0;
      repeat (gap - gap / 2 - 1) @(posedge clk_sys);
    end
  endtask
endmodule
`default_nettype wire

// ---- bench/triple_programmable_timer_tb.sv ----
/*
  Self-checking testbench for the three-channel timer: AXI4-Lite tasks and mode scenarios.
  Assumes tpt_timer at 40 MHz and the pin source model driving timer_in.
*/
`timescale 1ns/1ps
`default_nettype none
module triple_programmable_timer_tb;
  import tpt_pkg::*;
  logic clk_sys, rst_n;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, timer_in, timer_out, rr;
  logic [2:0] timer_irq_req;
  logic [15:0] rd;
  int errors = 0;
  int total_checks = 0;
  int lows, irqs, n;

  tpt_timer u_dut (.clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .timer_in, .timer_out, .timer_irq_req);
  tpt_pin_src u_src (.clk_sys(clk_sys), .pin(timer_in));

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic end_of_test();
    if (errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // address and data offered together, each released at its own handshake
  task automatic wr(input logic [9:0] idx, input logic [15:0] d, input logic [1:0] er);
    logic a_done, w_done;
    a_done = 1'b0;
    w_done = 1'b0;
    @(posedge clk_sys);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {16'h0000, d};
    s_axi_wstrb <= 4'h3;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(a_done && w_done)) begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready === 1'b1) begin
        a_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready === 1'b1) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask

  task automatic rd_reg(input logic [9:0] idx, output logic [15:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata[15:0];
    r = s_axi_rresp;
  endtask

  task automatic rchk(input logic [9:0] idx, input logic [15:0] e, input string nm);
    logic [15:0] d;
    logic [1:0] r;
    rd_reg(idx, d, r);
    chk(nm, {16'h0, e}, {16'h0, d});
    chk("rresp", {30'h0, TPT_RESP_OKAY}, {30'h0, r});
  endtask

  // one sample per clock of output-low cycles and request pulses
  task automatic watch(input int b, input int cyc, output int lo, output int ir);
    lo = 0;
    ir = 0;
    repeat (cyc) begin
      @(posedge clk_sys);
      if (b < 2 && timer_out[b] === 1'b0) lo++;
      if (timer_irq_req[b] === 1'b1) ir++;
    end
  endtask

  initial begin
    rst_n = 1'b0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    repeat (6) @(posedge clk_sys);
    chk("out_rst", 32'h3, {30'h0, timer_out});
    chk("irq_rst", 32'h0, {29'h0, timer_irq_req});
    rst_n <= 1'b1;
    rchk(TPT_T0_CTRL_IDX, 16'h0000, "t0_ctrl_rst");
    wr(TPT_T0_CTRL_IDX, 16'h8000, TPT_RESP_OKAY);
    rchk(TPT_T0_CTRL_IDX, 16'h0000, "t0_en_masked");
    // continuous single limit, gate high: period of three slots
    wr(TPT_T0_LIMA_IDX, 16'h0003, TPT_RESP_OKAY);
    wr(TPT_T0_CNT_IDX, 16'h0000, TPT_RESP_OKAY);
    u_src.set_level(0, 1'b1);
    wr(TPT_T0_CTRL_IDX, 16'he001, TPT_RESP_OKAY);
    repeat (24) @(posedge clk_sys);
    watch(0, 48, lows, irqs);
    chk("t0_low_cycles", 32'd4, lows);
    chk("t0_irqs", 32'd4, irqs);
    rchk(TPT_T0_CTRL_IDX, 16'ha021, "t0_flag_set");
    u_src.set_level(0, 1'b0);
    // let the falling gate clear the synchronizer so the snapshot below is final
    repeat (4) @(posedge clk_sys);
    rd_reg(TPT_T0_CNT_IDX, rd, rr);
    watch(0, 48, lows, irqs);
    chk("t0_gate_lows", 32'd0, lows);
    rchk(TPT_T0_CNT_IDX, rd, "t0_gate_hold");
    // run enable cleared through the mask, flag cleared by software
    wr(TPT_T0_CTRL_IDX, 16'h6001, TPT_RESP_OKAY);
    u_src.set_level(0, 1'b1);
    watch(0, 48, lows, irqs);
    chk("t0_halt_irqs", 32'd0, irqs);
    rchk(TPT_T0_CTRL_IDX, 16'h2001, "t0_flag_clr");
    // one-shot dual limit on timer1: A of four slots, B of three
    wr(TPT_T1_LIMA_IDX, 16'h0004, TPT_RESP_OKAY);
    wr(TPT_T1_LIMB_IDX, 16'h0003, TPT_RESP_OKAY);
    wr(TPT_T1_CNT_IDX, 16'h0000, TPT_RESP_OKAY);
    u_src.set_level(1, 1'b1);
    wr(TPT_T1_CTRL_IDX, 16'he002, TPT_RESP_OKAY);
    watch(1, 64, lows, irqs);
    chk("t1_b_low", 32'd12, lows);
    chk("t1_irqs", 32'd2, irqs);
    chk("t1_out", 32'h1, {31'h0, timer_out[1]});
    rchk(TPT_T1_CTRL_IDX, 16'h2022, "t1_oneshot");
    rchk(TPT_T1_CNT_IDX, 16'h0000, "t1_cnt");
    // external clocking: six edges at the closest legal spacing
    u_src.set_level(0, 1'b0);
    wr(TPT_T0_LIMA_IDX, 16'h0100, TPT_RESP_OKAY);
    wr(TPT_T0_CNT_IDX, 16'h0000, TPT_RESP_OKAY);
    wr(TPT_T0_CTRL_IDX, 16'hc005, TPT_RESP_OKAY);
    u_src.pulses(0, 6, 4);
    repeat (8) @(posedge clk_sys);
    rchk(TPT_T0_CNT_IDX, 16'h0006, "t0_ext_count");
    // retrigger one-shot: idle until the first edge
    u_src.set_level(1, 1'b0);
    wr(TPT_T1_LIMA_IDX, 16'h0005, TPT_RESP_OKAY);
    wr(TPT_T1_CNT_IDX, 16'h0003, TPT_RESP_OKAY);
    wr(TPT_T1_CTRL_IDX, 16'hc010, TPT_RESP_OKAY);
    repeat (24) @(posedge clk_sys);
    rchk(TPT_T1_CNT_IDX, 16'h0003, "t1_rtg_wait");
    u_src.pulses(1, 1, 4);
    // the edge may wait up to one slot before the clear lands
    repeat (4) @(posedge clk_sys);
    rd_reg(TPT_T1_CNT_IDX, rd, rr);
    chk("t1_rtg_cleared", 32'h1, {31'h0, rd < 16'h0003});
    repeat (40) @(posedge clk_sys);
    rchk(TPT_T1_CTRL_IDX, 16'h0030, "t1_rtg_halt");
    // count above the limit wraps through all-ones before matching
    wr(TPT_T2_LIMA_IDX, 16'h0002, TPT_RESP_OKAY);
    wr(TPT_T2_CNT_IDX, 16'hfffd, TPT_RESP_OKAY);
    wr(TPT_T2_CTRL_IDX, 16'he001, TPT_RESP_OKAY);
    n = 0;
    while (timer_irq_req[2] !== 1'b1 && n < 100) begin
      @(posedge clk_sys);
      n++;
    end
    chk("t2_wrap_delay", 32'h1, {31'h0, n >= 12 && n <= 24});
    // prescaled gate mode: timer2 terminal count every eight clocks drives timer0
    u_src.set_level(0, 1'b1);
    wr(TPT_T0_CTRL_IDX, 16'hc009, TPT_RESP_OKAY);
    wr(TPT_T0_CNT_IDX, 16'h0000, TPT_RESP_OKAY);
    repeat (80) @(posedge clk_sys);
    rd_reg(TPT_T0_CNT_IDX, rd, rr);
    chk("t0_prescale", 32'h1, {31'h0, rd >= 16'h0009 && rd <= 16'h000b});
    // second write clears a flag that a late terminal count may have set
    wr(TPT_T2_CTRL_IDX, 16'h401e, TPT_RESP_OKAY);
    wr(TPT_T2_CTRL_IDX, 16'h001e, TPT_RESP_OKAY);
    rchk(TPT_T2_CTRL_IDX, 16'h0000, "t2_hardwired");
    wr(TPT_T2_CNT_IDX, 16'h1234, TPT_RESP_OKAY);
    rchk(TPT_T2_CNT_IDX, 16'h1234, "t2_cnt_rw");
    // timer2 has no second limit register
    wr(10'h064, 16'h0055, TPT_RESP_SLVERR);
    rd_reg(10'h064, rd, rr);
    chk("unmapped_rresp", {30'h0, TPT_RESP_SLVERR}, {30'h0, rr});
    chk("unmapped_rdata", 32'h0, {16'h0, rd});
    end_of_test();
  end

  // the whole sequence needs well under three thousand clocks
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    end_of_test();
  end
endmodule
`default_nettype wire
